// ### hw/pmi_pkg.sv
// shared constants for the port media interface pin block
package pmi_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_TXCNT  = 8'h08;

   // ----------------------------------------
   // control field positions and reset value
   // ----------------------------------------
   localparam int CTRL_MODE_LO  = 0;
   localparam int CTRL_PHY_ROLE = 2;
   localparam int CTRL_REF_GEN  = 3;
   localparam int CTRL_SPEED_LO = 4;
   localparam int CTRL_SOFT_RST = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0014;

   // ----------------------------------------
   // interface modes and link speeds
   // ----------------------------------------
   localparam logic [1:0] MODE_MII   = 2'h0;
   localparam logic [1:0] MODE_RMII  = 2'h1;
   localparam logic [1:0] MODE_RGMII = 2'h2;
   localparam logic [1:0] SPEED_10   = 2'h0;
   localparam logic [1:0] SPEED_100  = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;

   // ----------------------------------------
   // clock figures
   // ----------------------------------------
   localparam longint SYS_CLK_HZ  = 125_000_000;
   localparam longint REF_RMII_HZ = 50_000_000;
   localparam longint CLK_GIG_HZ  = 125_000_000;
   localparam longint CLK_FAST_HZ = 25_000_000;
   localparam longint CLK_SLOW_HZ = 2_500_000;
   localparam longint NCO_ONE     = 64'h1_0000_0000;
   localparam logic [31:0] NCO_MAX  = 32'h8000_0000;
   localparam logic [31:0] INC_REF  = 32'((NCO_ONE * REF_RMII_HZ) / SYS_CLK_HZ);
   localparam logic [31:0] INC_FAST = 32'((NCO_ONE * CLK_FAST_HZ) / SYS_CLK_HZ);
   localparam logic [31:0] INC_SLOW = 32'((NCO_ONE * CLK_SLOW_HZ) / SYS_CLK_HZ);

   // ----------------------------------------
   // strap sampling after a soft reset
   // ----------------------------------------
   localparam logic [2:0] STRAP_HOLD = 3'h4;

endpackage

// ### hw/pmi_clkgen.sv
// phase accumulator making the device-driven interface clock
module pmi_clkgen (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // frequency selection
   input  wire logic [31:0] inc,
   // generated clock
   output logic             clk_out
);

   logic [31:0] phase_r;
   logic [31:0] phase_nxt;

   assign phase_nxt = phase_r + inc;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         phase_r <= 32'h0;
         clk_out <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         clk_out <= phase_r[31];
      end
   end

endmodule

// ### hw/pmi_txcap.sv
// transmit pin capture on the link clock with the mode crossed in from clk_sys
module pmi_txcap (
   // link clock domain
   input  wire logic       clk_link,
   input  wire logic       tx_enable,
   input  wire logic       tx_error,
   input  wire logic [3:0] tx_data,
   // mode from clk_sys, already a stable level
   input  wire logic [1:0] mode,
   // captured transmit stream, clk_link domain
   output logic            cap_enable,
   output logic            cap_error,
   output logic [3:0]      cap_data,
   // frame start toggle, clk_link domain
   output logic            frame_tgl
);

   logic [1:0] mode_s1;
   logic [1:0] mode_s2;
   logic       en_d;
   logic       err_mask;
   logic [3:0] data_mask;
   logic       tgl_r = 1'b0;

   // error only means something in mii; upper data bits dropped in rmii
   assign err_mask  = (mode_s2 == pmi_pkg::MODE_MII) ? tx_error : 1'b0;
   assign data_mask = (mode_s2 == pmi_pkg::MODE_RMII) ? 4'h3 : 4'hf;

   always_ff @(posedge clk_link) begin
      mode_s1 <= mode;
      mode_s2 <= mode_s1;
   end

   always_ff @(posedge clk_link) begin
      en_d       <= tx_enable;
      cap_enable <= tx_enable;
      cap_error  <= err_mask;
      cap_data   <= tx_data & data_mask;
   end

   assign frame_tgl = tgl_r;

   always_ff @(posedge clk_link) begin
      if (tx_enable && !en_d) begin
         tgl_r <= ~tgl_r;
      end
   end

endmodule

// ### hw/pmi_port.sv
// port media interface pin multiplexer with wishbone control
//
// Function
// - mii transmit clock 25/2.5 MHz; driven in phy role, input in mac role.
// - mii receive clock 25/2.5 MHz; driven in phy role, input in mac role.
// - rmii normal: far side supplies 50 MHz reference on transmit clock pin.
// - rmii clock mode: device drives 50 MHz reference on receive clock pin.
// - receive qualifier means valid, carrier-or-valid, or control per mode.
// - transmit error is taken only in mii; ignored otherwise.
// - collision only in mii: driven as phy, input as mac.
// - carrier sense only in mii: driven as phy, input as mac.
// - receive error driven only in mii; otherwise left undriven.
// - receive data four bits in mii/rgmii, only bits 1:0 in rmii.
// - receive data pins sampled as straps during resets, driven only afterwards.
// - receive data bit 0 has its own pin and is also a strap.
module pmi_port (
   // system clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // switch core receive side, clk_sys domain
   input  wire logic        core_rx_valid,
   input  wire logic        core_rx_error,
   input  wire logic [3:0]  core_rx_data,
   input  wire logic        core_carrier,
   input  wire logic        core_collision,
   // switch core transmit side, clk_tx_link domain
   output logic             core_tx_enable,
   output logic             core_tx_error,
   output logic [3:0]       core_tx_data,
   // mac-role inputs seen by the core, clk_sys domain
   output logic             core_carrier_in,
   output logic             core_collision_in,
   // transmit clock pin: input is the link clock
   input  wire logic        clk_tx_link,
   output logic             port_tx_clock_o,
   output logic             port_tx_clock_oe,
   // transmit pins
   input  wire logic        port_tx_enable,
   input  wire logic        port_tx_error,
   input  wire logic        port_tx_data_bit3,
   input  wire logic        port_tx_data_bit2,
   input  wire logic        port_tx_data_bit1,
   input  wire logic        port_tx_data_bit0,
   // collision pin
   input  wire logic        port_collision_i,
   output logic             port_collision_o,
   output logic             port_collision_oe,
   // receive clock pin
   input  wire logic        port_rx_clock_i,
   output logic             port_rx_clock_o,
   output logic             port_rx_clock_oe,
   // receive qualifier and error pins
   output logic             port_rx_valid_o,
   output logic             port_rx_valid_oe,
   output logic             port_rx_error_o,
   output logic             port_rx_error_oe,
   // carrier sense pin
   input  wire logic        port_carrier_sense_i,
   output logic             port_carrier_sense_o,
   output logic             port_carrier_sense_oe,
   // receive data pins, also straps
   input  wire logic [3:0]  port_rx_data_i,
   output logic [3:0]       port_rx_data_o,
   output logic [3:0]       port_rx_data_oe
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [31:0] ctrl_r;
   logic [31:0] txcnt_r;
   logic [3:0]  strap_r;
   logic [2:0]  soft_cnt_r;
   logic [3:0]  rxd_s1;
   logic [3:0]  rxd_s2;
   logic        crs_s1;
   logic        crs_s2;
   logic        col_s1;
   logic        col_s2;
   logic        rxclk_s1;
   logic        rxclk_s2;
   logic        rxclk_d;
   logic        rxclk_seen_r;
   logic        tgl_s1;
   logic        tgl_s2;
   logic        tgl_d;
   logic        frame_tgl;
   logic        gen_clk;
   logic [1:0]  mode;
   logic        phy_role;
   logic        ref_gen;
   logic [1:0]  speed;
   logic        is_mii;
   logic        is_rmii;
   logic        is_rgmii;
   logic        strap_phase;
   logic        wb_req;
   logic        wr_ctrl;
   logic [31:0] ctrl_nxt;
   logic [31:0] rd_data;
   logic [31:0] status;
   logic [31:0] inc_sel;
   logic        frame_evt;
   logic [3:0]  tx_data_pins;
   logic        tx_clk_oe_nxt;
   logic        rx_clk_oe_nxt;
   logic        col_oe_nxt;
   logic        crs_oe_nxt;
   logic        rx_valid_nxt;
   logic        rx_valid_oe_nxt;
   logic        rx_err_oe_nxt;
   logic [3:0]  rxd_mask;
   logic [3:0]  rxd_oe_nxt;

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   assign mode     = ctrl_r[pmi_pkg::CTRL_MODE_LO +: 2];
   assign phy_role = ctrl_r[pmi_pkg::CTRL_PHY_ROLE];
   assign ref_gen  = ctrl_r[pmi_pkg::CTRL_REF_GEN];
   assign speed    = ctrl_r[pmi_pkg::CTRL_SPEED_LO +: 2];
   assign is_mii   = (mode == pmi_pkg::MODE_MII);
   assign is_rmii  = (mode == pmi_pkg::MODE_RMII);
   assign is_rgmii = (mode == pmi_pkg::MODE_RGMII);
   // pins stay strap inputs while either reset runs
   assign strap_phase = reset || (soft_cnt_r != 3'h0);

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl  = wb_req && wb_we_i && (wb_adr_i == pmi_pkg::OFF_CTRL);
   assign ctrl_nxt = merge_bytes(ctrl_r, wb_dat_i, wb_sel_i);
   assign status = {24'h0, rxclk_seen_r, col_s2, crs_s2, 1'b0, strap_r};
   assign rd_data = (wb_adr_i == pmi_pkg::OFF_CTRL)   ? ctrl_r  :
                    (wb_adr_i == pmi_pkg::OFF_STATUS) ? status  :
                    (wb_adr_i == pmi_pkg::OFF_TXCNT)  ? txcnt_r : 32'h0;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl_r <= pmi_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= {ctrl_nxt[31:7], 1'b0, ctrl_nxt[5:0]};
      end
   end

   // soft reset bit starts a strap window, then self-clears
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         soft_cnt_r <= 3'h0;
      end else if (wr_ctrl && ctrl_nxt[pmi_pkg::CTRL_SOFT_RST]) begin
         soft_cnt_r <= pmi_pkg::STRAP_HOLD;
      end else if (soft_cnt_r != 3'h0) begin
         soft_cnt_r <= soft_cnt_r - 3'h1;
      end
   end

   // ----------------------------------------
   // pin input synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      rxd_s1   <= port_rx_data_i;
      rxd_s2   <= rxd_s1;
      crs_s1   <= port_carrier_sense_i;
      crs_s2   <= crs_s1;
      col_s1   <= port_collision_i;
      col_s2   <= col_s1;
      rxclk_s1 <= port_rx_clock_i;
      rxclk_s2 <= rxclk_s1;
      tgl_s1   <= frame_tgl;
      tgl_s2   <= tgl_s1;
   end

   // straps follow the pins throughout reset, hold the last value after
   always_ff @(posedge clk_sys) begin
      if (strap_phase) begin
         strap_r <= rxd_s2;
      end
   end

   // ----------------------------------------
   // mac-role inputs and link activity
   // ----------------------------------------
   assign frame_evt = tgl_s2 ^ tgl_d;
   // edge history follows the pins in reset, so no false edge after it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tgl_d             <= tgl_s2;
         rxclk_d           <= rxclk_s2;
         rxclk_seen_r      <= 1'b0;
         txcnt_r           <= 32'h0;
         core_carrier_in   <= 1'b0;
         core_collision_in <= 1'b0;
      end else begin
         tgl_d             <= tgl_s2;
         rxclk_d           <= rxclk_s2;
         rxclk_seen_r      <= rxclk_seen_r | (rxclk_s2 ^ rxclk_d);
         txcnt_r           <= txcnt_r + {31'h0, frame_evt};
         core_carrier_in   <= is_mii && !phy_role && crs_s2;
         core_collision_in <= is_mii && !phy_role && col_s2;
      end
   end

   // ----------------------------------------
   // clock generation
   // ----------------------------------------
   // rmii forces 50 MHz in either clock setting; gigabit steps half the accumulator, toggling every cycle
   assign inc_sel = (is_rmii)                ? pmi_pkg::INC_REF  :
                    (speed == pmi_pkg::SPEED_1000) ? pmi_pkg::NCO_MAX :
                    (speed == pmi_pkg::SPEED_100)  ? pmi_pkg::INC_FAST :
                                                     pmi_pkg::INC_SLOW;

   pmi_clkgen u_clkgen (
      .clk_sys (clk_sys),
      .reset   (reset),
      .inc     (inc_sel),
      .clk_out (gen_clk)
   );

   // ----------------------------------------
   // transmit capture in the link domain
   // ----------------------------------------
   assign tx_data_pins = {port_tx_data_bit3, port_tx_data_bit2,
                          port_tx_data_bit1, port_tx_data_bit0};
   pmi_txcap u_txcap (
      .clk_link   (clk_tx_link),
      .tx_enable  (port_tx_enable),
      .tx_error   (port_tx_error),
      .tx_data    (tx_data_pins),
      .mode       (mode),
      .cap_enable (core_tx_enable),
      .cap_error  (core_tx_error),
      .cap_data   (core_tx_data),
      .frame_tgl  (frame_tgl)
   );

   // ----------------------------------------
   // pin direction decode (oe low drives)
   // ----------------------------------------
   assign tx_clk_oe_nxt   = !(is_mii && phy_role);
   assign rx_clk_oe_nxt   = !((is_mii && phy_role) || (is_rmii && ref_gen) || is_rgmii);
   assign col_oe_nxt      = !(is_mii && phy_role);
   assign crs_oe_nxt      = !(is_mii && phy_role);
   assign rx_err_oe_nxt   = !is_mii;
   assign rx_valid_oe_nxt = !(is_mii || is_rmii || is_rgmii);
   assign rxd_mask        = is_rmii ? 4'h3 : 4'hf;
   assign rxd_oe_nxt      = strap_phase ? 4'hf : ~rxd_mask;
   // rmii qualifier merges carrier with valid
   assign rx_valid_nxt = is_rmii ? (core_carrier | core_rx_valid) : core_rx_valid;

   // ----------------------------------------
   // registered pin outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port_tx_clock_oe      <= 1'b1;
         port_rx_clock_oe      <= 1'b1;
         port_collision_oe     <= 1'b1;
         port_carrier_sense_oe <= 1'b1;
         port_rx_error_oe      <= 1'b1;
         port_rx_valid_oe      <= 1'b1;
      end else begin
         port_tx_clock_oe      <= tx_clk_oe_nxt;
         port_rx_clock_oe      <= rx_clk_oe_nxt;
         port_collision_oe     <= col_oe_nxt;
         port_carrier_sense_oe <= crs_oe_nxt;
         port_rx_error_oe      <= rx_err_oe_nxt;
         port_rx_valid_oe      <= rx_valid_oe_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port_rx_data_oe <= 4'hf;
         port_rx_data_o  <= 4'h0;
      end else begin
         port_rx_data_oe <= rxd_oe_nxt;
         port_rx_data_o  <= core_rx_data & rxd_mask;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port_tx_clock_o      <= 1'b0;
         port_rx_clock_o      <= 1'b0;
         port_collision_o     <= 1'b0;
         port_carrier_sense_o <= 1'b0;
         port_rx_error_o      <= 1'b0;
         port_rx_valid_o      <= 1'b0;
      end else begin
         port_tx_clock_o      <= gen_clk;
         port_rx_clock_o      <= gen_clk;
         port_collision_o     <= core_collision && is_mii;
         port_carrier_sense_o <= core_carrier && is_mii;
         port_rx_error_o      <= core_rx_error && is_mii;
         port_rx_valid_o      <= rx_valid_nxt;
      end
   end

endmodule

// ### test/pmi_port_assertions.sv
// concurrent checks on the bus and pins of the port pin block
module pmi_port_assertions (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        reset,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // core receive side
   input wire logic        core_rx_valid,
   input wire logic        core_rx_error,
   input wire logic        core_carrier,
   // pins
   input wire logic        port_tx_clock_oe,
   input wire logic        port_collision_oe,
   input wire logic        port_rx_clock_oe,
   input wire logic        port_carrier_sense_oe,
   input wire logic        port_rx_valid_o,
   input wire logic        port_rx_error_o,
   input wire logic        port_rx_error_oe,
   input wire logic [3:0]  port_rx_data_o,
   input wire logic [3:0]  port_rx_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_req;
      $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o;
   endproperty
   a_ack_req: assert property (p_ack_req) else $error("request not acked next cycle");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   // ----------------------------------------
   // pins
   // ----------------------------------------
   property p_strap;
      $fell(reset) |-> port_rx_data_oe == 4'hf;
   endproperty
   a_strap: assert property (p_strap) else $error("rx data driven during reset");
   property p_phy_group;
      !port_collision_oe |-> !port_carrier_sense_oe && !port_tx_clock_oe && !port_rx_clock_oe;
   endproperty
   a_phy_group: assert property (p_phy_group) else $error("phy role pins split");
   property p_valid_mii;
      port_rx_data_oe == 4'h0 && $stable(port_rx_data_oe) |->
         port_rx_valid_o == $past(core_rx_valid);
   endproperty
   a_valid_mii: assert property (p_valid_mii) else $error("rx valid wrong");
   property p_valid_rmii;
      port_rx_data_oe == 4'hc && $stable(port_rx_data_oe) |->
         port_rx_valid_o == $past(core_carrier || core_rx_valid);
   endproperty
   a_valid_rmii: assert property (p_valid_rmii) else $error("carrier valid wrong");
   property p_err_mii;
      !port_rx_error_oe && $stable(port_rx_error_oe) |-> port_rx_error_o == $past(core_rx_error);
   endproperty
   a_err_mii: assert property (p_err_mii) else $error("rx error not passed");
   property p_rmii_hi;
      port_rx_data_oe == 4'hc |-> port_rx_data_o[3:2] == 2'h0 && port_rx_error_oe;
   endproperty
   a_rmii_hi: assert property (p_rmii_hi) else $error("rmii upper bits used");
   c_ack: cover property (wb_ack_o);
   c_phy: cover property (!port_collision_oe);
   c_rmii: cover property (port_rx_data_oe == 4'hc);
endmodule

bind pmi_port pmi_port_assertions u_chk (.*);

// ### test/pmi_far_model.sv
// far side mac or phy model at the port pins
module pmi_far_model (
   // link clock
   output logic       clk_far,
   // transmit pins
   output logic       port_tx_enable,
   output logic       port_tx_error,
   output logic       port_tx_data_bit3,
   output logic       port_tx_data_bit2,
   output logic       port_tx_data_bit1,
   output logic       port_tx_data_bit0,
   // strap levels and receive data wires
   input  wire logic [3:0] strap,
   input  wire logic [3:0] port_rx_data_o,
   input  wire logic [3:0] port_rx_data_oe,
   output logic [3:0]      port_rx_data_i,
   // shared pins
   input  wire logic  port_carrier_sense_o,
   input  wire logic  port_carrier_sense_oe,
   output logic       port_carrier_sense_i,
   input  wire logic  port_collision_o,
   input  wire logic  port_collision_oe,
   output logic       port_collision_i,
   input  wire logic  port_rx_clock_o,
   input  wire logic  port_rx_clock_oe,
   output logic       port_rx_clock_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {port_tx_enable, port_tx_error} = 2'h0;
      {port_tx_data_bit3, port_tx_data_bit2, port_tx_data_bit1, port_tx_data_bit0} = 4'h0;
      clk_far = 1'b0;
      #7;
      forever #15 clk_far = ~clk_far;
   end
   assign port_rx_data_i = (port_rx_data_oe & strap) | (~port_rx_data_oe & port_rx_data_o);
   assign port_carrier_sense_i = port_carrier_sense_oe ? 1'b1 : port_carrier_sense_o;
   assign port_collision_i = port_collision_oe ? 1'b1 : port_collision_o;
   assign port_rx_clock_i = port_rx_clock_oe ? clk_far : port_rx_clock_o;
   task send(input logic [3:0] d, input logic e);
      @(posedge clk_far);
      port_tx_enable <= 1'b1;
      port_tx_error <= e;
      {port_tx_data_bit3, port_tx_data_bit2, port_tx_data_bit1, port_tx_data_bit0} <= d;
   endtask
   task idle();
      @(posedge clk_far);
      {port_tx_enable, port_tx_error} <= 2'h0;
      {port_tx_data_bit3, port_tx_data_bit2, port_tx_data_bit1, port_tx_data_bit0} <= 4'h0;
   endtask
endmodule

// ### test/tb_pmi_port.sv
// testbench for the port media interface pin block
module tb_pmi_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ref_loop, clk_far;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, core_rx_data, core_tx_data, strap, port_rx_data_i;
   logic [3:0] port_rx_data_o, port_rx_data_oe;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic core_rx_valid, core_rx_error, core_carrier, core_collision;
   logic core_tx_enable, core_tx_error, core_carrier_in, core_collision_in;
   logic clk_tx_link, port_tx_clock_o, port_tx_clock_oe, port_tx_enable, port_tx_error;
   logic port_tx_data_bit3, port_tx_data_bit2, port_tx_data_bit1, port_tx_data_bit0;
   logic port_collision_i, port_collision_o, port_collision_oe;
   logic port_rx_clock_i, port_rx_clock_o, port_rx_clock_oe, port_rx_valid_o, port_rx_valid_oe;
   logic port_rx_error_o, port_rx_error_oe;
   logic port_carrier_sense_i, port_carrier_sense_o, port_carrier_sense_oe;
   int n_fail, n_checks, n_rxe, n_txe;
   // ctrl, clock edges in 200 cycles, pin enables and levels
   localparam logic [33:0] MT [0:6] = '{
      {8'h10, 8'h00, 10'h390, 1'h1, 1'h0, 4'hf, 2'h3},
      {8'h14, 8'h28, 10'h000, 1'h1, 1'h0, 4'hf, 2'h0},
      {8'h11, 8'h00, 10'h3bc, 1'h0, 1'h1, 4'h3, 2'h0},
      {8'h19, 8'h50, 10'h33c, 1'h0, 1'h1, 4'h3, 2'h0},
      {8'h22, 8'h64, 10'h330, 1'h0, 1'h0, 4'hf, 2'h0},
      {8'h26, 8'h64, 10'h330, 1'h0, 1'h0, 4'hf, 2'h0},
      {8'h04, 8'h04, 10'h000, 1'h1, 1'h0, 4'hf, 2'h0}};
   localparam logic [13:0] TT [0:2] = '{{8'h10, 6'h3f}, {8'h11, 6'h23}, {8'h22, 6'h2f}};
   pmi_port dut (.*);
   pmi_far_model far (.*);
   assign clk_tx_link = !port_tx_clock_oe ? port_tx_clock_o :
                        (ref_loop ? port_rx_clock_o : clk_far);
   always @(posedge port_rx_clock_o) n_rxe++;
   always @(posedge port_tx_clock_o) n_txe++;
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, s};
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task finish_test();
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
   initial begin
      {reset, ref_loop, strap} = {2'h2, 4'ha};
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = 47'h0;
      {core_rx_valid, core_rx_error, core_carrier, core_collision, core_rx_data} = 8'h7f;
      {n_fail, n_checks, n_rxe, n_txe} = 0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      wb(1'b0, pmi_pkg::OFF_CTRL, 32'h0, 4'hf);
      chk(q, pmi_pkg::CTRL_RESET);
      wb(1'b0, pmi_pkg::OFF_STATUS, 32'h0, 4'hf);
      chk(q[3:0], 4'ha);
      wb(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
      wb(1'b0, 8'h0c, 32'h0, 4'hf);
      chk(q, 32'h0);
      for (int i = 0; i < 7; i++) begin
         ref_loop <= (MT[i][33:26] == 8'h19);
         wb(1'b1, pmi_pkg::OFF_CTRL, 32'(MT[i][33:26]), 4'hf);
         repeat (5) @(posedge clk_sys);
         #1;
         chk({port_tx_clock_oe, port_collision_oe, port_rx_clock_oe, port_rx_valid_oe,
              port_rx_error_oe, port_carrier_sense_oe, port_rx_data_oe, port_rx_error_o,
              port_rx_valid_o, port_rx_data_o, core_carrier_in, core_collision_in},
             32'(MT[i][17:0]));
         chk({port_collision_o, port_carrier_sense_o}, {2{MT[i][27:26] == 2'h0}});
         n_rxe = 0;
         n_txe = 0;
         repeat (200) @(posedge clk_sys);
         if (MT[i][25:18] != 8'h00)
            chk(n_rxe >= MT[i][25:18] - 1 && n_rxe <= MT[i][25:18] + 1, 32'h1);
         if (!MT[i][17])
            chk(n_txe >= MT[i][25:18] - 1 && n_txe <= MT[i][25:18] + 1, 32'h1);
      end
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, pmi_pkg::OFF_CTRL, 32'(TT[i][13:6]), 4'hf);
         repeat (4) @(posedge clk_sys);
         far.send(4'hf, 1'b1);
         @(posedge clk_far);
         #1;
         chk({core_tx_enable, core_tx_error, core_tx_data}, 32'(TT[i][5:0]));
         far.idle();
         repeat (3) @(posedge clk_far);
      end
      repeat (10) @(posedge clk_sys);
      wb(1'b0, pmi_pkg::OFF_TXCNT, 32'h0, 4'hf);
      chk(q, 32'h3);
      wb(1'b1, pmi_pkg::OFF_CTRL, 32'h14, 4'h0);
      wb(1'b0, pmi_pkg::OFF_CTRL, 32'h0, 4'hf);
      chk(q, 32'h22);
      strap <= 4'h5;
      wb(1'b1, pmi_pkg::OFF_CTRL, 32'h54, 4'hf);
      repeat (8) @(posedge clk_sys);
      wb(1'b0, pmi_pkg::OFF_STATUS, 32'h0, 4'hf);
      chk({q[7], q[3:0]}, 32'h15);
      wb(1'b0, pmi_pkg::OFF_CTRL, 32'h0, 4'hf);
      chk(q, 32'h14);
      finish_test();
   end
endmodule
